// *** rtl/tca_pkg.sv ***
// Constants shared by the transfer controller activation and count block
package tca_pkg;
   localparam int EN_REGS = 8;
   localparam int EN_W = 16;
   localparam int SRC_N = 128;
   localparam int VEC_W = 7;
   localparam int BC_W = 16;
   localparam int ADDR_W = 8;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] EN_BASE_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] EN_LAST_OFS = 8'h1c;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h20;
   // ----------------------------------------
   // Control register fields and reset values
   // ----------------------------------------
   localparam int RRS_BIT = 4;
   localparam int REPEAT_CHAIN_ENABLE_BIT = 3;
   localparam int ERR_BIT = 0;
   localparam logic [EN_W-1:0] EN_RST = 16'h0000;
   localparam logic [BC_W-1:0] BC_RST = 16'h0000;
   localparam logic [BC_W-1:0] BC_LAST = 16'h0001;
   localparam logic [VEC_W-1:0] VEC_RST = 7'h00;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** rtl/transfer_ctrl_activation_count.sv ***
// Activation enables, block counter, control register and AXI4-Lite slave
`timescale 1ns/10ps
// Summary of operation
// [RL1] Block mode: 16-bit count, minus one per block
// [RL2] At zero: clear enable, then interrupt CPU
// [RL3] Count 1 is one, 0 means 65,536
// [RL4] Count used only in block mode, no CPU access
// [RL5] Eight 16-bit enable registers, reset to zero
// [RL6] Enabled source activates controller, not CPU
// [RL7] Enable bit clears on zero after reading one
// [RL8] Per-transfer select clears enable every transfer
// [RL9] Enable cleared when programmed count completes
// [RL10] Otherwise enable bit stays set
// [RL11] Software changes enables by single-bit operations
// [RL12] Initial multi-bit set needs dummy read first
// [RL13] Control bits 7 to 5 read zero
// [RL14] Each activation compares vector with previous one
// [RL15] Match with skip enabled: no information fetch
// [RL16] After chain activation always fetch information
// [RL17] Stop flag: writing one has no effect
// [RL18] Address error or NMI sets stop flag, halts
// [RL19] Repeat chain enable allows chain at reload
// [RL20] Interrupt per transfer, or only at completion
// [RL21] After reset previous vector is invalid
module transfer_ctrl_activation_count
   import tca_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [tca_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tca_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [tca_pkg::SRC_N-1:0] srcReq,
   output logic [tca_pkg::SRC_N-1:0] dtcReq,
   output logic [tca_pkg::SRC_N-1:0] cpuReq,
   input wire logic actStart,
   input wire logic [tca_pkg::VEC_W-1:0] actVector,
   output logic skipFetch,
   output logic decideValid,
   input wire logic xferEnd,
   input wire logic [tca_pkg::VEC_W-1:0] xferSrc,
   input wire logic xferDisel,
   input wire logic xferChain,
   input wire logic countDone,
   input wire logic blockMode,
   input wire logic repeatReload,
   input wire logic chainReq,
   output logic chainGo,
   input wire logic bcLoad,
   input wire logic [tca_pkg::BC_W-1:0] bcValue,
   output logic [tca_pkg::BC_W-1:0] blockCount,
   input wire logic addrErr,
   input wire logic nmi,
   output logic halted,
   output logic cpuIrq,
   output logic [tca_pkg::VEC_W-1:0] cpuIrqSrc
);
   import tca_pkg::*;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rstMeta_r;
   logic rstN;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_r <= 1'b0;
         rstN <= 1'b0;
      end
      else
      begin
         rstMeta_r <= 1'b1;
         rstN <= rstMeta_r;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [EN_W-1:0] en_r [EN_REGS];
   logic [EN_W-1:0] seen_r [EN_REGS];
   logic [EN_W-1:0] en_nxt [EN_REGS];
   logic [EN_W-1:0] seen_nxt [EN_REGS];
   logic [SRC_N-1:0] enFlat;
   logic rrs_r;
   logic repeat_chain_enable_r;
   logic err_r;
   logic errSeen_r;
   logic err_nxt;
   logic [BC_W-1:0] bcnt_r;
   logic [BC_W-1:0] bcnt_nxt;
   logic [VEC_W-1:0] prevVec_r;
   logic prevValid_r;
   logic prevChain_r;
   logic skip_r;
   logic decide_r;
   logic chainGo_r;
   logic irq_r;
   logic [VEC_W-1:0] irqSrc_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   wire rdTake = s_axi_arvalid & ~rvalid_r;
   wire wAlign = s_axi_awaddr[1:0] == 2'h0;
   wire rAlign = s_axi_araddr[1:0] == 2'h0;
   wire wIsEn = wAlign && s_axi_awaddr <= EN_LAST_OFS;
   wire rIsEn = rAlign && s_axi_araddr <= EN_LAST_OFS;
   wire wIsCtl = s_axi_awaddr == CTRL_OFS;
   wire rIsCtl = s_axi_araddr == CTRL_OFS;
   wire [2:0] wIdx = s_axi_awaddr[4:2];
   wire [2:0] rIdx = s_axi_araddr[4:2];
   wire [EN_W-1:0] wMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire [EN_W-1:0] wVal = s_axi_wdata[EN_W-1:0];
   wire ctlWr = wrTake & wIsCtl & s_axi_wstrb[0];
   wire [31:0] ctlRd = {24'h00_0000, 3'h0, rrs_r, repeat_chain_enable_r, 2'h0, err_r}; // [RL13]
   wire [31:0] enRd = {16'h0000, en_r[rIdx]};
   wire [31:0] rdMux = rIsEn ? enRd : (rIsCtl ? ctlRd : RD_ZERO);

   // ----------------------------------------
   // Transfer end decisions
   // ----------------------------------------
   wire bcDone = bcnt_r == BC_LAST;
   wire done = blockMode ? bcDone : countDone; // [RL1] [RL9]
   // Chained continuation keeps the enable; the last link decides
   wire clrEvt = xferEnd & ~xferChain & (xferDisel | done); // [RL8] [RL9] [RL10] [RL20]
   wire [SRC_N-1:0] clrMask = clrEvt ? (SRC_N'(1) << xferSrc) : '0;
   wire errSet = addrErr | nmi; // [RL18]
   wire vecMatch = actVector == prevVec_r; // [RL14]
   wire canSkip = prevValid_r & ~prevChain_r & rrs_r & vecMatch; // [RL15] [RL16] [RL21]

   always_comb
   begin
      for (int i = 0; i < EN_REGS; i++)
      begin
         en_nxt[i] = en_r[i] & ~clrMask[i*EN_W +: EN_W];
         seen_nxt[i] = seen_r[i];
         if (rdTake && rIsEn && rIdx == 3'(i))
         begin
            seen_nxt[i] = en_r[i]; // [RL12]
         end
         if (wrTake && wIsEn && wIdx == 3'(i))
         begin
            // A zero only clears a bit that was seen as one
            en_nxt[i] = (wMask & (wVal | (en_nxt[i] & ~seen_r[i]))) | (~wMask & en_nxt[i]); // [RL7] [RL11]
            seen_nxt[i] = seen_nxt[i] & ~wMask;
         end
      end
   end

   // Hardware set beats a same-cycle software clear
   assign err_nxt = errSet | (err_r & ~(ctlWr & ~s_axi_wdata[ERR_BIT] & errSeen_r)); // [RL17] [RL18]

   always_comb
   begin
      bcnt_nxt = bcnt_r;
      if (bcLoad)
      begin
         bcnt_nxt = bcValue;
      end
      else if (xferEnd && blockMode)
      begin
         bcnt_nxt = bcnt_r - BC_LAST; // [RL1] [RL3] [RL4]
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         for (int i = 0; i < EN_REGS; i++)
         begin
            en_r[i] <= EN_RST; // [RL5]
            seen_r[i] <= EN_RST;
         end
      end
      else
      begin
         en_r <= en_nxt;
         seen_r <= seen_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         rrs_r <= 1'b0;
         repeat_chain_enable_r <= 1'b0;
         err_r <= 1'b0;
         errSeen_r <= 1'b0;
      end
      else
      begin
         err_r <= err_nxt;
         if (ctlWr)
         begin
            rrs_r <= s_axi_wdata[RRS_BIT];
            repeat_chain_enable_r <= s_axi_wdata[REPEAT_CHAIN_ENABLE_BIT];
            errSeen_r <= 1'b0;
         end
         else if (rdTake && rIsCtl)
         begin
            errSeen_r <= err_r;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         bcnt_r <= BC_RST;
      end
      else
      begin
         bcnt_r <= bcnt_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         prevVec_r <= VEC_RST;
         prevValid_r <= 1'b0; // [RL21]
         prevChain_r <= 1'b0;
         skip_r <= 1'b0;
         decide_r <= 1'b0;
      end
      else
      begin
         decide_r <= actStart;
         if (actStart)
         begin
            skip_r <= canSkip; // [RL15]
            prevVec_r <= actVector; // [RL14]
            prevValid_r <= 1'b1;
         end
         if (xferEnd)
         begin
            prevChain_r <= xferChain; // [RL16]
         end
      end
   end

   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         irq_r <= 1'b0;
         irqSrc_r <= VEC_RST;
         chainGo_r <= 1'b0;
      end
      else
      begin
         // Interrupt rises in the same cycle as the enable clear
         irq_r <= clrEvt; // [RL2] [RL20]
         if (clrEvt)
         begin
            irqSrc_r <= xferSrc;
         end
         chainGo_r <= xferEnd & chainReq & (~repeatReload | repeat_chain_enable_r); // [RL19]
      end
   end

   // ----------------------------------------
   // Bus responses
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= RD_ZERO;
      end
      else
      begin
         if (wrTake)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (wIsEn | wIsCtl) ? RESP_OKAY : RESP_DECERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
         if (rdTake)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= (rIsEn | rIsCtl) ? RESP_OKAY : RESP_DECERR;
            rdata_r <= rdMux;
         end
         else if (s_axi_rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   generate
      for (genvar g = 0; g < EN_REGS; g++)
      begin : gFlat
         assign enFlat[g*EN_W +: EN_W] = en_r[g];
      end
   endgenerate

   // Stop flag does not mask routing; engine must honour halted
   assign dtcReq = srcReq & enFlat; // [RL6]
   assign cpuReq = srcReq & ~enFlat; // [RL6]
   assign s_axi_awready = wrTake;
   assign s_axi_wready = wrTake;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = rdTake;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign skipFetch = skip_r;
   assign decideValid = decide_r;
   assign chainGo = chainGo_r;
   assign blockCount = bcnt_r;
   assign halted = err_r; // [RL18]
   assign cpuIrq = irq_r;
   assign cpuIrqSrc = irqSrc_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstN);

   bc_dec_a: assert property (xferEnd && blockMode && !bcLoad |=> bcnt_r == $past(bcnt_r) - BC_LAST) // [RL1]
      else $error("block count did not step down");
   clr_irq_a: assert property (clrEvt && !wrTake |=> cpuIrq && !enFlat[$past(xferSrc)]) // [RL2]
      else $error("enable not cleared before interrupt");
   bc_wrap_a: assert property (bcnt_r == BC_RST && xferEnd && blockMode && !bcLoad |=> bcnt_r == 16'hffff) // [RL3]
      else $error("zero count not treated as 65536");
   bc_hold_a: assert property (!bcLoad && !(xferEnd && blockMode) |=> $stable(bcnt_r)) // [RL4]
      else $error("block count moved outside block mode");
   route_a: assert property ((dtcReq & cpuReq) == '0 && (dtcReq | cpuReq) == srcReq) // [RL6]
      else $error("request routed wrongly");
   en_keep_a: assert property (xferEnd && !xferDisel && !done && !wrTake
      |=> enFlat[$past(xferSrc)] == $past(enFlat[xferSrc])) // [RL10]
      else $error("enable changed before completion");
   err_one_a: assert property (!err_r && !errSet |=> !err_r) // [RL17]
      else $error("stop flag set without cause");
   err_set_a: assert property (errSet |=> halted [*2] or (halted ##1 1'b1)) // [RL18]
      else $error("stop flag not set on error");
   skip_hit_a: assert property (actStart && canSkip |=> skipFetch && decideValid) // [RL15]
      else $error("read skip not taken");
   chain_fetch_a: assert property (actStart && prevChain_r |=> decideValid && !skipFetch) // [RL16]
      else $error("fetch skipped after chain");
   first_fetch_a: assert property (actStart && !prevValid_r |=> !skipFetch) // [RL21]
      else $error("first activation skipped fetch");
   chain_rep_a: assert property (xferEnd && chainReq && repeatReload && !repeat_chain_enable_r |=> !chainGo) // [RL19]
      else $error("chain allowed at reload");

   cov_skip_c: cover property (actStart && canSkip ##1 skipFetch);
   cov_bdone_c: cover property (xferEnd && blockMode && bcDone ##1 cpuIrq);
   cov_err_c: cover property (errSet ##1 halted ##[1:40] !halted);
   cov_per_transfer_irq_select_c: cover property (xferEnd && xferDisel && !done ##1 cpuIrq);

endmodule

// *** tb/tca_far_engine.sv ***
// Behavioural transfer engine that ends data transfers on request
`timescale 1ns/10ps
module tca_far_engine
   import tca_pkg::*;
(
   input wire logic mclk,
   input wire logic go,
   input wire logic [tca_pkg::VEC_W-1:0] src,
   input wire logic [3:0] flags,
   input wire logic [3:0] dly,
   input wire logic halted,
   output logic busy,
   output logic xferEnd,
   output logic [tca_pkg::VEC_W-1:0] xferSrc,
   output logic [3:0] xferFlags
);
   logic [3:0] cnt_r;
   initial
   begin
      busy = 1'b0;
      xferEnd = 1'b0;
      xferSrc = '0;
      xferFlags = '0;
      cnt_r = '0;
   end
   always @(posedge mclk)
   begin
      xferEnd <= 1'b0;
      if (!xferEnd)
      begin
         // Released lines hold their value one cycle after xferEnd, else invert
         xferSrc <= ~xferSrc;
         xferFlags <= ~xferFlags;
      end
      if (go && !busy)
      begin
         busy <= 1'b1;
         cnt_r <= dly;
      end
      else if (busy && !halted)
      begin
         if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
         else
         begin
            busy <= 1'b0;
            xferEnd <= 1'b1;
            xferSrc <= src;
            xferFlags <= flags;
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the activation and block count block
`timescale 1ns/10ps
module tb_top;
   import tca_pkg::*;
   logic mclk = 0, rst_b = 0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [SRC_N-1:0] srcReq = '0, dtcReq, cpuReq;
   logic actStart = 0, skipFetch, decideValid, xferEnd, xferDisel, xferChain, countDone, blockMode;
   logic [VEC_W-1:0] actVector = '0, xferSrc, cpuIrqSrc, src = '0;
   logic repeatReload = 0, chainReq = 0, chainGo, bcLoad = 0, addrErr = 0, nmi = 0, halted, cpuIrq;
   logic go = 0, busy;
   logic [BC_W-1:0] bcValue = '0, blockCount;
   logic [3:0] flags = '0, dly = '0, xferFlags;
   int failCount = 0, testsRun = 0, irqN = 0, goN = 0;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} row_t;
   row_t rows[4] = '{'{8'h00, 32'h0000_8001, 32'h0000_8001, RESP_OKAY},
      '{8'h1c, 32'h0001_0002, 32'h0000_0002, RESP_OKAY},
      '{8'h20, 32'h0000_001f, 32'h0000_0018, RESP_OKAY},
      '{8'h24, 32'h0000_0001, 32'h0000_0000, RESP_DECERR}};
   assign {xferDisel, xferChain, countDone, blockMode} = xferFlags;
   always #50 mclk = ~mclk;
   always @(posedge mclk)
   begin
      if (cpuIrq === 1'b1)
         irqN <= irqN + 1;
      if (chainGo === 1'b1)
         goN <= goN + 1;
   end
   transfer_ctrl_activation_count u_transfer_ctrl_activation_count (.mclk, .rst_b, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srcReq, .dtcReq, .cpuReq, .actStart,
      .actVector, .skipFetch, .decideValid, .xferEnd, .xferSrc, .xferDisel, .xferChain, .countDone,
      .blockMode, .repeatReload, .chainReq, .chainGo, .bcLoad, .bcValue, .blockCount, .addrErr, .nmi,
      .halted, .cpuIrq, .cpuIrqSrc);
   tca_far_engine u_tca_far_engine (.mclk, .go, .src, .flags, .dly, .halted, .busy, .xferEnd,
      .xferSrc, .xferFlags);
   // ----------------------------------------
   // Bus, event and compare tasks
   // ----------------------------------------
   task automatic cw(input logic [31:0] g, input logic [31:0] e);
      testsRun++;
      if (g !== e)
      begin
         failCount++;
         $display("mismatch t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cb(input logic g, input logic e);
      cw({31'h0, g}, {31'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic xs(input logic [6:0] s, input logic [3:0] f, input logic [3:0] d);
      src <= s;
      flags <= f;
      dly <= d;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask
   task automatic xw();
      do @(posedge mclk); while (busy);
      repeat (3) @(posedge mclk);
   endtask
   task automatic act(input logic [6:0] v, input logic s);
      actVector <= v;
      actStart <= 1'b1;
      @(posedge mclk);
      actStart <= 1'b0;
      @(posedge mclk);
      cb(decideValid, 1'b1);
      cb(skipFetch, s);
   endtask
   task automatic ld(input logic [15:0] v);
      bcValue <= v;
      bcLoad <= 1'b1;
      @(posedge mclk);
      bcLoad <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic finishTest();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 9; i++)
      begin
         rdr(8'(4 * i));
         cw(rd, 32'h0000_0000);
      end
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         cw({30'h0, rsp}, {30'h0, rows[i].e});
         rdr(rows[i].a);
         cw(rd, rows[i].r);
         cw({30'h0, rsp}, {30'h0, rows[i].e});
      end
      // Upper lane only: the lower byte must keep its old value
      s_axi_wstrb <= 4'h2;
      wr(8'h1c, 32'h0000_ff01);
      s_axi_wstrb <= 4'hf;
      rdr(8'h1c);
      cw(rd, 32'h0000_ff02);
      rdr(8'h08);
      wr(8'h08, 32'h0000_0003);
      rdr(8'h08);
      cw(rd, 32'h0000_0003);
      $display("test registers ended");
      act(7'd3, 1'b0);
      act(7'd3, 1'b1);
      act(7'd4, 1'b0);
      act(7'd4, 1'b1);
      xs(7'd4, 4'b0100, 4'd0);
      xw();
      act(7'd4, 1'b0);
      srcReq <= 128'h3;
      @(posedge mclk);
      cw({30'h0, dtcReq[1:0]}, 32'h1);
      cw({30'h0, cpuReq[1:0]}, 32'h2);
      wr(8'h00, 32'h0000_0000);
      rdr(8'h00);
      cw(rd, 32'h0000_0000);
      wr(8'h00, 32'h0000_0001);
      wr(8'h00, 32'h0000_0000);
      rdr(8'h00);
      cw(rd, 32'h0000_0001);
      wr(8'h00, 32'h0000_0000);
      cb(cpuReq[0], 1'b1);
      $display("test activation ended");
      wr(8'h00, 32'h0000_0020);
      xs(7'd5, 4'b1000, 4'd0);
      xw();
      cw(irqN, 1);
      cw({25'h0, cpuIrqSrc}, 32'h5);
      rdr(8'h00);
      cw(rd, 32'h0000_0000);
      wr(8'h00, 32'h0000_0020);
      xs(7'd5, 4'b0000, 4'd1);
      xw();
      rdr(8'h00);
      cw(rd, 32'h0000_0020);
      xs(7'd5, 4'b0010, 4'd0);
      xw();
      rdr(8'h00);
      cw(rd, 32'h0000_0000);
      cw(irqN, 2);
      wr(8'h04, 32'h0000_0001);
      ld(16'h0002);
      cw({16'h0, blockCount}, 32'h2);
      xs(7'd16, 4'b0001, 4'd0);
      xw();
      cw({16'h0, blockCount}, 32'h1);
      xs(7'd16, 4'b0001, 4'd0);
      xw();
      rdr(8'h04);
      cw(rd, 32'h0000_0000);
      cw(irqN, 3);
      ld(16'h0000);
      wr(8'h04, 32'h0000_0001);
      xs(7'd16, 4'b0001, 4'd0);
      xw();
      cw({16'h0, blockCount}, 32'h0000_ffff);
      xs(7'd16, 4'b0000, 4'd0);
      xw();
      cw({16'h0, blockCount}, 32'h0000_ffff);
      rdr(8'h04);
      cw(rd, 32'h0000_0001);
      $display("test counting ended");
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h00, 32'h0000_0040);
         {nmi, addrErr} <= 2'(1 << k);
         @(posedge mclk);
         {nmi, addrErr} <= 2'b00;
         @(posedge mclk);
         cb(halted, 1'b1);
         xs(7'd6, 4'b1000, 4'd2);
         repeat (6) @(posedge mclk);
         cw(irqN, 3 + k);
         rdr(8'h20);
         cw(rd, 32'h0000_0019);
         wr(8'h20, 32'h0000_0019);
         cb(halted, 1'b1);
         wr(8'h20, 32'h0000_0018);
         cb(halted, 1'b1);
         rdr(8'h20);
         wr(8'h20, 32'h0000_0018);
         cb(halted, 1'b0);
         xw();
         cw(irqN, 4 + k);
      end
      $display("test stop flag ended");
      chainReq <= 1'b1;
      repeatReload <= 1'b1;
      xs(7'd9, 4'b0100, 4'd0);
      xw();
      cw(goN, 1);
      wr(8'h20, 32'h0000_0010);
      xs(7'd9, 4'b0100, 4'd0);
      xw();
      cw(goN, 1);
      repeatReload <= 1'b0;
      xs(7'd9, 4'b0100, 4'd0);
      xw();
      cw(goN, 2);
      $display("test chain ended");
      // Reset in mid-run: state and the stored vector must be forgotten
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      cw({16'h0, blockCount}, 32'h0);
      cw({25'h0, cpuIrqSrc}, 32'h0);
      cb(halted, 1'b0);
      rdr(8'h04);
      cw(rd, 32'h0000_0000);
      rdr(8'h20);
      cw(rd, 32'h0000_0000);
      wr(8'h20, 32'h0000_0010);
      act(7'd0, 1'b0);
      act(7'd0, 1'b1);
      $display("test reset ended");
      finishTest();
   end
   // Run needs a few hundred cycles; one millisecond is ample
   initial
   begin
      #1_000_000;
      failCount++;
      finishTest();
   end
endmodule
